// ==== pkg/smc_params.svh ====
// Purpose: constants for the sleep mode controller
// Assumes: 20 MHz system clock
// Notes: included by smc_ctrl only, not by smc_pkg or smc_wait
// Function
// - Sleep needs arm bit then sleep instruction.
// - Code 000 idle stops core and progmem.
// - Idle wakes on any enabled interrupt.
// - Code 001 stops periph, core, progmem clocks.
// - Noise reduction entry starts enabled conversion.
// - Noise reduction wakes on listed sources only.
// - Timer runs there only if asynchronous; code keeps its clock on in noise reduction either way and gates only its wake.
// - Code 010 power-down stops all clocks.
// - Power-down wakes on listed async sources only.
// - Non-idle modes wake external irqs by level.
// - Power-down wake waits start-up time-out.
// - Core halted four cycles beyond start-up.
// - Register file and SRAM kept across sleep.
// - Reset in sleep restarts at reset vector.
// - Brown-out off in non-idle, non-noise sleep when sleep-off set, back on wake.
// - Wake after brown-out off takes 60 us.
// - Sleep-off bit resets 0, timed write.
// - Code 011 power-save keeps async timer.
// - Codes 110/111 keep oscillator, six-cycle wake.
// - Mode field bits 3:1, 100/101 reserved.
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH
`define SMC_CLK_MHZ 20
`define SMC_MODE_LSB 1
`define SMC_MODE_MSB 3
`define SMC_ARM_BIT 0
`define SMC_CTRL_RESET 8'h00
`define SMC_BOSO_RESET 1'b0
`define SMC_HALT_CYCLES 4
`define SMC_STANDBY_CYCLES 6
`define SMC_BOD_WAKE_US 60
`define SMC_BOD_WAKE_CYCLES ((`SMC_BOD_WAKE_US) * (`SMC_CLK_MHZ))
`define SMC_BOSO_WINDOW 4
`define SMC_STARTUP_CYCLES 1024
`endif

// ==== pkg/smc_pkg.sv ====
// Purpose: types for the sleep mode controller
// Assumes: smc_params.svh constants
// Notes: no functions, types only
package smc_pkg;
	typedef enum logic [2:0] {
		SMC_M_IDLE = 3'h0,
		SMC_M_NOISE = 3'h1,
		SMC_M_PDOWN = 3'h2,
		SMC_M_PSAVE = 3'h3,
		SMC_M_RES4 = 3'h4,
		SMC_M_RES5 = 3'h5,
		SMC_M_STBY = 3'h6,
		SMC_M_XSTBY = 3'h7
	} smc_mode_t;

	// Clock domain enables, one bit per domain
	typedef struct packed {
		logic core;
		logic progmem;
		logic periph;
		logic converter;
		logic async_timer;
		logic main_osc;
		logic timer_osc;
	} smc_clk_en_t;

	// Wake requests, already qualified by their own enables
	typedef struct packed {
		logic ext_zero;
		logic ext_one;
		logic ext_zero_level;
		logic ext_one_level;
		logic pin_change;
		logic two_wire_match;
		logic async_timer;
		logic mem_ready;
		logic conv_done;
		logic watchdog;
		logic other_io;
	} smc_wake_t;
endpackage

// ==== hw/smc_wait.sv ====
// Purpose: loadable down-counter timing wake delays
// Assumes: load and count on one clock
// Notes: done is high in the last counted cycle, so a load of N waits N cycles
`timescale 1ns/10ps
module smc_wait #(
	parameter int WIDTH = 16
) (
	input wire logic clk, // System clock
	input wire logic rst_sync_b, // Synchronised reset, low active
	input wire logic load, // Load a new count
	input wire logic [WIDTH-1:0] count, // Cycles to wait
	input wire logic abort, // Drop any running wait
	output logic busy, // Counting
	output logic done // Last counted cycle
);
	logic [WIDTH-1:0] cnt_q;

	initial begin
		if (WIDTH < 4) begin
			$error("smc_wait width too small");
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cnt_q <= '0;
		end else if (abort) begin
			cnt_q <= '0;
		end else if (load) begin
			cnt_q <= count;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - WIDTH'(1);
		end
	end

	// Combinational: a registered flag would stretch every wait by one cycle
	assign done = !abort && (cnt_q == WIDTH'(1));
	assign busy = (cnt_q != '0);
endmodule // smc_wait

// ==== hw/smc_ctrl.sv ====
// Purpose: sleep mode controller, clock gating and wake sequencing
// Assumes: wake inputs from pins pass synchronisers here
// Notes: core reset vector handled by the core on core_reset
`timescale 1ns/10ps
`include "smc_params.svh"
module smc_ctrl #(
	parameter int STARTUP_CYCLES = `SMC_STARTUP_CYCLES,
	parameter int BOD_WAKE_CYCLES = `SMC_BOD_WAKE_CYCLES
) (
	input wire logic clk, // 20 MHz system clock
	input wire logic rst_b, // Async reset, low active
	input wire logic [7:0] ctrl_wdata, // Sleep control reg write data
	input wire logic ctrl_we, // Sleep control reg write strobe
	output logic [7:0] ctrl_rdata, // Sleep control reg read data
	input wire logic boso_wdata, // Brown-out sleep-off write data
	input wire logic boso_unlock, // Timed-sequence enable write
	input wire logic boso_we, // Brown-out sleep-off write strobe
	output logic boso_rdata, // Brown-out sleep-off state
	input wire logic sleep_instr, // Core executes sleep instruction
	input wire logic conv_enabled, // Converter enabled
	input wire logic timer_async, // Timer clocked asynchronously
	input wire logic ext_reset_pin, // External reset request, pin
	input wire logic sys_reset, // Watchdog or brown-out reset
	input wire smc_pkg::smc_wake_t wake_in, // Enabled wake sources
	output smc_pkg::smc_clk_en_t clk_en, // Clock domain enables
	output logic comparator_off, // Comparator powered down
	output logic brownout_on, // Brown-out detector enable
	output logic conv_start, // Start conversion pulse
	output logic asleep, // Device in a sleep mode
	output logic core_halt, // Core held
	output logic core_resume, // Core resumes, run handler
	output logic core_reset, // Core restarts at reset vector
	output logic reserved_sleep // Last sleep ignored, reserved code
);
	typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_START, ST_HALT} smc_st_t;

	localparam int WW = 16;

	logic rst_m_q, rst_sync_b;
	logic [1:0] wk_meta_q, wk_sync_q;
	logic erst_meta_q, erst_q;
	logic [7:0] ctrl_q;
	logic boso_q;
	logic [2:0] unlock_cnt_q;
	smc_st_t st_q;
	smc_pkg::smc_mode_t mode_q;
	logic bod_off_q;
	logic via_irq_q;
	logic wake;
	logic rst_wake;
	logic deep;
	logic [WW-1:0] start_cnt;
	logic wt_load, wt_busy, wt_done, wt_abort;
	smc_pkg::smc_mode_t sel;

	initial begin
		if (STARTUP_CYCLES < 1 || STARTUP_CYCLES >= (1 << WW) || BOD_WAKE_CYCLES >= (1 << WW)) begin
			$error("smc_ctrl wait count out of range");
		end
	end

	// ==========================================
	// Reset and pin synchronisers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_m_q <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_sync_b <= rst_m_q;
		end
	end

	// External level irqs and reset come from pins
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			wk_meta_q <= 2'h0;
			wk_sync_q <= 2'h0;
			erst_meta_q <= 1'b0;
			erst_q <= 1'b0;
		end else begin
			wk_meta_q <= {wake_in.ext_zero_level, wake_in.ext_one_level};
			wk_sync_q <= wk_meta_q;
			erst_meta_q <= ext_reset_pin;
			erst_q <= erst_meta_q;
		end
	end

	// ==========================================
	// Control registers
	assign sel = smc_pkg::smc_mode_t'(ctrl_q[`SMC_MODE_MSB:`SMC_MODE_LSB]);
	assign ctrl_rdata = {4'h0, ctrl_q[`SMC_MODE_MSB:`SMC_ARM_BIT]};
	assign boso_rdata = boso_q;

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ctrl_q <= `SMC_CTRL_RESET;
		end else if (ctrl_we) begin
			ctrl_q <= {4'h0, ctrl_wdata[3:0]};
		end
	end

	// Timed write: unlock opens a short window for one write
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			unlock_cnt_q <= 3'h0;
		end else if (boso_unlock) begin
			unlock_cnt_q <= 3'(`SMC_BOSO_WINDOW);
		end else if (boso_we) begin
			unlock_cnt_q <= 3'h0;
		end else if (unlock_cnt_q != 3'h0) begin
			unlock_cnt_q <= unlock_cnt_q - 3'h1;
		end
	end

	// Hardware clears the bit once sleep is entered
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			boso_q <= `SMC_BOSO_RESET;
		end else if (boso_we && unlock_cnt_q != 3'h0) begin
			boso_q <= boso_wdata;
		end else if (st_q == ST_SLEEP) begin
			boso_q <= 1'b0;
		end
	end

	// ==========================================
	// Wake qualification
	always_comb begin
		rst_wake = erst_q || sys_reset;
		wake = 1'b0;
		unique case (mode_q)
			smc_pkg::SMC_M_IDLE: begin
				wake = wake_in.ext_zero || wake_in.ext_one || wake_in.pin_change || wake_in.two_wire_match
					|| wake_in.async_timer || wake_in.mem_ready || wake_in.conv_done
					|| wake_in.watchdog || wake_in.other_io;
			end
			smc_pkg::SMC_M_NOISE: begin
				wake = wake_in.conv_done || wake_in.watchdog || wake_in.two_wire_match
					|| (wake_in.async_timer && timer_async) || wake_in.mem_ready
					|| (|wk_sync_q) || wake_in.pin_change;
			end
			smc_pkg::SMC_M_PDOWN, smc_pkg::SMC_M_STBY: begin
				wake = wake_in.watchdog || wake_in.two_wire_match || (|wk_sync_q) || wake_in.pin_change;
			end
			smc_pkg::SMC_M_PSAVE, smc_pkg::SMC_M_XSTBY: begin
				wake = wake_in.watchdog || wake_in.two_wire_match || (|wk_sync_q) || wake_in.pin_change
					|| (wake_in.async_timer && timer_async);
			end
			default: begin
				wake = 1'b0;
			end
		endcase
	end

	assign deep = (mode_q != smc_pkg::SMC_M_IDLE) && (mode_q != smc_pkg::SMC_M_NOISE);

	// ==========================================
	// Sleep sequencer
	always_comb begin
		start_cnt = WW'(1);
		if (bod_off_q) begin
			start_cnt = WW'(BOD_WAKE_CYCLES);
		end else if (mode_q == smc_pkg::SMC_M_STBY || mode_q == smc_pkg::SMC_M_XSTBY) begin
			start_cnt = WW'(`SMC_STANDBY_CYCLES);
		end else if (mode_q == smc_pkg::SMC_M_PDOWN || mode_q == smc_pkg::SMC_M_PSAVE) begin
			start_cnt = WW'(STARTUP_CYCLES);
		end
	end

	assign wt_abort = rst_wake;
	assign wt_load = (st_q == ST_SLEEP && wake && !rst_wake) || (st_q == ST_START && wt_done);

	smc_wait #(
		.WIDTH(WW)
	) u_wait (
		.clk(clk),
		.rst_sync_b(rst_sync_b),
		.load(wt_load),
		.count(st_q == ST_SLEEP ? start_cnt : WW'(`SMC_HALT_CYCLES)),
		.abort(wt_abort),
		.busy(wt_busy),
		.done(wt_done)
	);

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			st_q <= ST_RUN;
		end else if (rst_wake && st_q != ST_RUN) begin
			st_q <= ST_RUN;
		end else begin
			unique case (st_q)
				ST_RUN: begin
					if (sleep_instr && ctrl_q[`SMC_ARM_BIT] && sel != smc_pkg::SMC_M_RES4
						&& sel != smc_pkg::SMC_M_RES5) begin
						st_q <= ST_SLEEP;
					end
				end
				ST_SLEEP: begin
					if (wake) begin
						st_q <= ST_START;
					end
				end
				ST_START: begin
					if (wt_done) begin
						st_q <= ST_HALT;
					end
				end
				ST_HALT: begin
					if (wt_done) begin
						st_q <= ST_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			mode_q <= smc_pkg::SMC_M_IDLE;
			bod_off_q <= 1'b0;
		end else if (st_q == ST_RUN && sleep_instr && ctrl_q[`SMC_ARM_BIT]) begin
			mode_q <= sel;
			bod_off_q <= boso_q && (sel != smc_pkg::SMC_M_IDLE) && (sel != smc_pkg::SMC_M_NOISE);
		end else if (st_q == ST_RUN) begin
			bod_off_q <= 1'b0;
		end
	end

	// Deep modes: every wake source gone by start-up end, wake without handler
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			via_irq_q <= 1'b0;
		end else if (st_q == ST_SLEEP) begin
			via_irq_q <= 1'b1;
		end else if (st_q == ST_START && wt_done) begin
			via_irq_q <= !(deep && (|wk_sync_q) == 1'b0 && !wake);
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			conv_start <= 1'b0;
			core_resume <= 1'b0;
			core_reset <= 1'b0;
			reserved_sleep <= 1'b0;
		end else begin
			conv_start <= st_q == ST_RUN && sleep_instr && ctrl_q[`SMC_ARM_BIT]
				&& sel == smc_pkg::SMC_M_NOISE && conv_enabled;
			core_resume <= st_q == ST_HALT && wt_done && via_irq_q;
			core_reset <= rst_wake && st_q != ST_RUN;
			if (st_q == ST_RUN && sleep_instr && ctrl_q[`SMC_ARM_BIT]) begin
				reserved_sleep <= sel == smc_pkg::SMC_M_RES4 || sel == smc_pkg::SMC_M_RES5;
			end
		end
	end

	// ==========================================
	// Clock domain enables; memories stay powered, never cleared
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			clk_en <= '1;
			comparator_off <= 1'b0;
			brownout_on <= 1'b1;
			asleep <= 1'b0;
		end else begin
			asleep <= st_q == ST_SLEEP;
			brownout_on <= !(st_q == ST_SLEEP && bod_off_q);
			comparator_off <= st_q == ST_SLEEP && deep;
			if (st_q == ST_SLEEP) begin
				clk_en.core <= 1'b0;
				clk_en.progmem <= 1'b0;
				clk_en.periph <= mode_q == smc_pkg::SMC_M_IDLE;
				clk_en.converter <= mode_q == smc_pkg::SMC_M_IDLE || mode_q == smc_pkg::SMC_M_NOISE;
				clk_en.async_timer <= !deep || ((mode_q == smc_pkg::SMC_M_PSAVE
					|| mode_q == smc_pkg::SMC_M_XSTBY) && timer_async);
				clk_en.main_osc <= !deep || mode_q == smc_pkg::SMC_M_STBY || mode_q == smc_pkg::SMC_M_XSTBY;
				clk_en.timer_osc <= !deep || mode_q == smc_pkg::SMC_M_PSAVE || mode_q == smc_pkg::SMC_M_XSTBY;
			end else if (st_q == ST_START) begin
				clk_en <= '1;
				clk_en.core <= 1'b0;
				clk_en.progmem <= 1'b0;
			end else begin
				clk_en <= '1;
			end
		end
	end

	assign core_halt = st_q != ST_RUN;

	// ==========================================
	// Checks
	sequence s_halt_four;
		(st_q == ST_HALT) [*4] ##1 (st_q != ST_HALT);
	endsequence

	property p_halt_len;
		@(posedge clk) disable iff (!rst_sync_b)
		(st_q == ST_START && wt_done && !rst_wake) |=> s_halt_four;
	endproperty
	a_halt_len: assert property (p_halt_len) else $error("halt not four cycles");

	property p_enter;
		@(posedge clk) disable iff (!rst_sync_b)
		(st_q == ST_RUN && sleep_instr && !ctrl_q[`SMC_ARM_BIT]) |=> st_q == ST_RUN;
	endproperty
	a_enter: assert property (p_enter) else $error("sleep without arm");

	property p_idle_clk;
		@(posedge clk) disable iff (!rst_sync_b)
		(st_q == ST_SLEEP && mode_q == smc_pkg::SMC_M_IDLE) |=> (!clk_en.core && clk_en.periph);
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("idle clocks wrong");

	property p_noise_clk;
		@(posedge clk) disable iff (!rst_sync_b)
		(st_q == ST_SLEEP && mode_q == smc_pkg::SMC_M_NOISE) |=> (!clk_en.periph && clk_en.converter);
	endproperty
	a_noise_clk: assert property (p_noise_clk) else $error("noise clocks wrong");

	property p_pdown_clk;
		@(posedge clk) disable iff (!rst_sync_b)
		(st_q == ST_SLEEP && mode_q == smc_pkg::SMC_M_PDOWN) |=> (!clk_en.main_osc && !clk_en.converter);
	endproperty
	a_pdown_clk: assert property (p_pdown_clk) else $error("power-down clocks run");

	property p_reset_wake;
		@(posedge clk) disable iff (!rst_sync_b)
		(st_q == ST_SLEEP && rst_wake) |=> (core_reset && st_q == ST_RUN);
	endproperty
	a_reset_wake: assert property (p_reset_wake) else $error("reset did not restart");

	property p_bod_off;
		@(posedge clk) disable iff (!rst_sync_b)
		(st_q == ST_SLEEP && !bod_off_q) |=> brownout_on;
	endproperty
	a_bod_off: assert property (p_bod_off) else $error("detector off wrongly");

	property p_conv;
		@(posedge clk) disable iff (!rst_sync_b)
		conv_start |-> $past(sel) == smc_pkg::SMC_M_NOISE;
	endproperty
	a_conv: assert property (p_conv) else $error("conversion start outside noise mode");

	property p_reserved;
		@(posedge clk) disable iff (!rst_sync_b)
		(st_q == ST_RUN && (sel == smc_pkg::SMC_M_RES4 || sel == smc_pkg::SMC_M_RES5)) |=> st_q == ST_RUN;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code slept");

	property p_pdown_edge;
		@(posedge clk) disable iff (!rst_sync_b)
		(st_q == ST_SLEEP && mode_q == smc_pkg::SMC_M_PDOWN && !wk_sync_q[0] && !wk_sync_q[1]
			&& !wake_in.pin_change && !wake_in.watchdog && !wake_in.two_wire_match && !rst_wake) |=> st_q == ST_SLEEP;
	endproperty
	a_pdown_edge: assert property (p_pdown_edge) else $error("power-down woke by other source");
endmodule // smc_ctrl

// ==== verif/smc_core_model.sv ====
// Purpose: core and wake-source stand-in for the sleep controller
// Assumes: drives only just after rising edges
// Notes: misbehaves only where a bench task asks it to
`timescale 1ns/10ps
module smc_core_model (
	input wire logic clk, // System clock
	output logic [7:0] ctrl_wdata, // Control write data
	output logic ctrl_we, // Control write strobe
	output logic boso_wdata, // Sleep-off value
	output logic boso_unlock, // Timed-sequence enable
	output logic boso_we, // Sleep-off write strobe
	output logic sleep_instr, // Sleep instruction
	output smc_pkg::smc_wake_t wake_in // Wake sources
);
	initial begin
		ctrl_wdata = 8'h00;
		ctrl_we = 1'b0;
		boso_wdata = 1'b0;
		boso_unlock = 1'b0;
		boso_we = 1'b0;
		sleep_instr = 1'b0;
		wake_in = '0;
	end
	// ==========
	// Software side
	task automatic set_ctrl(input logic [2:0] mode, input logic arm);
		@(posedge clk);
		ctrl_wdata <= {4'h0, mode, arm};
		ctrl_we <= 1'b1;
		@(posedge clk);
		ctrl_we <= 1'b0;
	endtask
	// Arm bit is written before this
	task automatic do_sleep();
		@(posedge clk);
		sleep_instr <= 1'b1;
		@(posedge clk);
		sleep_instr <= 1'b0;
	endtask
	// Untimed call shows the write being refused
	task automatic set_off(input logic v, input logic timed);
		if (timed) begin
			@(posedge clk);
			boso_unlock <= 1'b1;
			@(posedge clk);
			boso_unlock <= 1'b0;
		end
		@(posedge clk);
		boso_wdata <= v;
		boso_we <= 1'b1;
		@(posedge clk);
		boso_we <= 1'b0;
	endtask
	// ==========
	// Wake sources; a short hold breaks the start-up rule
	task automatic wake(input smc_pkg::smc_wake_t w, input int hold);
		@(posedge clk);
		wake_in <= w;
		repeat (hold) @(posedge clk);
		wake_in <= '0;
	endtask
endmodule // smc_core_model

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench for the sleep mode controller
// Assumes: short start-up counts via parameters
// Notes: latencies checked in a window, not to the cycle
`timescale 1ns/10ps
module tb_top;
	localparam int STARTUP = 8;
	localparam int OFF_WAKE = 30;
	logic clk, rst_b, conv_enabled, timer_async, ext_reset_pin, sys_reset;
	logic [7:0] ctrl_wdata, ctrl_rdata;
	logic ctrl_we, boso_wdata, boso_unlock, boso_we, boso_rdata, sleep_instr;
	logic comparator_off, brownout_on, conv_start, asleep;
	logic core_halt, core_resume, core_reset, reserved_sleep;
	smc_pkg::smc_wake_t wake_in;
	smc_pkg::smc_clk_en_t clk_en;
	int bad_count = 0;
	int n_tests = 0;
	smc_ctrl #(.STARTUP_CYCLES(STARTUP), .BOD_WAKE_CYCLES(OFF_WAKE)) u_smc_ctrl (.clk(clk), .rst_b(rst_b),
		.ctrl_wdata(ctrl_wdata), .ctrl_we(ctrl_we), .ctrl_rdata(ctrl_rdata), .boso_wdata(boso_wdata),
		.boso_unlock(boso_unlock), .boso_we(boso_we), .boso_rdata(boso_rdata), .sleep_instr(sleep_instr),
		.conv_enabled(conv_enabled), .timer_async(timer_async), .ext_reset_pin(ext_reset_pin),
		.sys_reset(sys_reset), .wake_in(wake_in), .clk_en(clk_en), .comparator_off(comparator_off),
		.brownout_on(brownout_on), .conv_start(conv_start), .asleep(asleep), .core_halt(core_halt),
		.core_resume(core_resume), .core_reset(core_reset), .reserved_sleep(reserved_sleep));
	smc_core_model u_smc_core_model (.clk(clk), .ctrl_wdata(ctrl_wdata), .ctrl_we(ctrl_we),
		.boso_wdata(boso_wdata), .boso_unlock(boso_unlock), .boso_we(boso_we),
		.sleep_instr(sleep_instr), .wake_in(wake_in));
	// ==========
	// Checking and closing
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic chk_in(input int v, input int lo, input int hi, input string msg);
		n_tests++;
		if (v < lo || v > hi) begin
			bad_count++;
			$display("[FAIL] %0t %s %0d not in %0d..%0d", $time, msg, v, lo, hi);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Order: core, progmem, periph, converter, async timer, main osc, timer osc
	function automatic logic [6:0] exp_clk(input logic [2:0] m, input logic ta);
		case (m)
			3'h0: return 7'h1F;
			3'h1: return 7'h0F;
			3'h3: return {4'h0, ta, 2'b01};
			3'h6: return 7'h02;
			3'h7: return {4'h0, ta, 2'b11};
			default: return 7'h00;
		endcase
	endfunction
	// ==========
	// Shared steps
	task automatic enter(input logic [2:0] m);
		logic cs;
		u_smc_core_model.set_ctrl(m, 1'b1);
		#1;
		chk(ctrl_rdata, {4'h0, m, 1'b1}, "ctrl readback");
		u_smc_core_model.do_sleep();
		#1;
		chk(core_halt, 1'b1, "halt on sleep");
		cs = conv_start;
		@(posedge clk);
		#1;
		cs = cs | conv_start;
		chk(asleep, 1'b1, "asleep");
		chk(clk_en, exp_clk(m, timer_async), "gating");
		chk(cs, m == 3'h1 && conv_enabled, "conversion start");
		chk(comparator_off, m > 3'h1, "comparator off");
	endtask
	task automatic wait_res(output int lat, output logic res, output logic rst);
		lat = 0;
		res = 1'b0;
		rst = 1'b0;
		do begin
			@(posedge clk);
			#1;
			lat++;
			res = res | core_resume;
			rst = rst | core_reset;
		end while (core_halt !== 1'b0 && lat < 3000);
	endtask
	task automatic wake_check(input smc_pkg::smc_wake_t w, input int hold, input int n, input logic er);
		int lat;
		logic res, rst;
		fork
			u_smc_core_model.wake(w, hold);
			wait_res(lat, res, rst);
		join
		// Drive edge, sample edge, n start cycles, four halt cycles; pin levels add two
		chk_in(lat, n + 6, n + 8, "wake latency");
		chk(res, er, "handler run");
		chk(clk_en, 8'h7F, "clocks back");
		chk(brownout_on, 1'b1, "detector back");
	endtask
	// ==========
	// Scenarios
	task automatic refusals();
		u_smc_core_model.set_ctrl(3'h2, 1'b0);
		u_smc_core_model.do_sleep();
		repeat (2) @(posedge clk);
		#1;
		chk({core_halt, asleep}, 8'h00, "unarmed sleep");
		for (int c = 4; c < 6; c++) begin
			u_smc_core_model.set_ctrl(c[2:0], 1'b1);
			u_smc_core_model.do_sleep();
			repeat (2) @(posedge clk);
			#1;
			chk({core_halt, asleep, reserved_sleep}, 8'h01, "reserved code");
		end
	endtask
	task automatic mode_table();
		smc_pkg::smc_wake_t w;
		logic [2:0] md[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
		int nn[6] = '{1, 1, STARTUP, STARTUP, 6, 6};
		int sx[6] = '{10, 2, 8, 5, 7, 4};
		for (int i = 0; i < 6; i++) begin
			w = '0;
			w[sx[i]] = 1'b1;
			enter(md[i]);
			wake_check(w, nn[i] + 12, nn[i], 1'b1);
		end
	endtask
	// Edge irqs, timer, memory, converter, other io must not wake
	task automatic no_wake();
		smc_pkg::smc_wake_t w;
		int sx[9] = '{10, 9, 4, 3, 2, 0, 10, 9, 0};
		for (int i = 0; i < 9; i++) begin
			w = '0;
			w[sx[i]] = 1'b1;
			enter(i < 6 ? 3'h2 : 3'h1);
			u_smc_core_model.wake(w, 15);
			#1;
			chk({asleep, core_halt}, 8'h03, "stray wake");
			w = '0;
			w.watchdog = 1'b1;
			wake_check(w, STARTUP + 12, i < 6 ? STARTUP : 1, 1'b1);
		end
	endtask
	task automatic brownout();
		smc_pkg::smc_wake_t w;
		w = '0;
		w.ext_zero = 1'b1;
		w.ext_zero_level = 1'b1;
		u_smc_core_model.set_off(1'b1, 1'b0);
		#1;
		chk(boso_rdata, 1'b0, "untimed write");
		u_smc_core_model.set_off(1'b1, 1'b1);
		#1;
		chk(boso_rdata, 1'b1, "timed write");
		enter(3'h0);
		chk(brownout_on, 1'b1, "idle keeps detector");
		wake_check(w, 13, 1, 1'b1);
		u_smc_core_model.set_off(1'b1, 1'b1);
		enter(3'h2);
		chk({brownout_on, boso_rdata}, 8'h00, "detector off");
		wake_check(w, OFF_WAKE + 12, OFF_WAKE, 1'b1);
		enter(3'h2);
		wake_check(w, 2, STARTUP, 1'b0);
	endtask
	// Synchronous timer, converter off: no timer wake, no automatic start
	task automatic sync_timer();
		smc_pkg::smc_wake_t w;
		@(posedge clk);
		timer_async <= 1'b0;
		conv_enabled <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			w = '0;
			w.async_timer = 1'b1;
			enter(i == 0 ? 3'h1 : 3'h3);
			u_smc_core_model.wake(w, 15);
			#1;
			chk({asleep, core_halt}, 8'h03, "sync timer wake");
			w = '0;
			w.watchdog = 1'b1;
			wake_check(w, STARTUP + 12, i == 0 ? 1 : STARTUP, 1'b1);
		end
		@(posedge clk);
		timer_async <= 1'b1;
		conv_enabled <= 1'b1;
	endtask
	task automatic reset_in_sleep();
		int lat;
		logic res, rst;
		for (int i = 0; i < 2; i++) begin
			enter(3'h2);
			@(posedge clk);
			sys_reset <= (i == 0);
			ext_reset_pin <= (i == 1);
			fork
				begin
					repeat (3) @(posedge clk);
					sys_reset <= 1'b0;
					ext_reset_pin <= 1'b0;
				end
				wait_res(lat, res, rst);
			join
			chk({res, rst}, 8'h01, "reset vector");
		end
	endtask
	// ==========
	// Clock, sequence, watchdog
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		rst_b = 1'b0;
		conv_enabled = 1'b1;
		timer_async = 1'b1;
		ext_reset_pin = 1'b0;
		sys_reset = 1'b0;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(ctrl_rdata, 8'h00, "ctrl reset");
		chk({boso_rdata, brownout_on, asleep}, 8'h02, "reset state");
		chk(clk_en, 8'h7F, "reset clocks");
		refusals();
		mode_table();
		no_wake();
		sync_timer();
		brownout();
		reset_in_sleep();
		report_and_stop();
	end
	// Whole run needs under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		report_and_stop();
	end
endmodule // tb_top
